/* File: rtl/cpu_status_control_regs.sv */
// Behaviour
// - Program counter is 23 bits wide, four million instruction words.
// - Single-cycle instructions except flow change, double move, table ops.
// - Repeat loops can be interrupted at any iteration.
// - Sixteen 16-bit working registers; the last is the stack pointer.
// - Upper 32 KB data space maps onto program memory via 8-bit page.
// - One cycle does read, register read, write and fetch together.
// - 17x17 multiplier, all sign modes, one cycle per multiply.
// - Division takes 19 cycles, interruptible at each cycle boundary.
// - Vectored exceptions: eight traps, 118 sources, seven levels.
// - All core registers are memory mapped, read and write.
// - Bit 8 half carry from bit 4 or bit 8; bits 15-9 read zero.
// - Bits 7-5 hold low priority bits; seven blocks user interrupts.
// - Priority bits become read-only while nesting disable is one.
// - Control bit 3 sits above status priority bits, levels 8-15.
// - Bit 4 shows a running repeat loop, read-only.
// - Bit 3 set on negative result, cleared otherwise.
// - Bit 2 set on signed overflow, cleared otherwise.
// - Bit 1 cleared by non-zero result, set by zero result.
// - Bit 0 set on carry out of most significant bit.
// - Priority msb set blocks user interrupts; software may only clear it.
// - Control bit 2 enables program space window; bits other than 3 and 2 read zero.
// - For subtraction carry and half carry act as borrows.
`default_nettype none
module cpu_status_control_regs #(
	parameter int PC_W   = cpu_status_pkg::PC_W,
	parameter int PAGE_W = cpu_status_pkg::PAGE_W
) (
	input  wire logic                       i_core_clk,
	input  wire logic                       i_sys_rst,
	input  wire cpu_status_pkg::alu_flags_t i_alu,
	input  wire cpu_status_pkg::reg_wr_t    i_wr,
	input  wire logic                       i_loop_running,
	input  wire logic                       i_nesting_disable,
	input  wire logic                       i_exc_ipl_we,
	input  wire logic [3:0]                 i_exc_ipl,
	input  wire logic                       i_pc_we,
	input  wire logic [PC_W-1:0]            i_pc_nxt,
	input  wire logic                       i_page_we,
	input  wire logic [PAGE_W-1:0]          i_page,
	output logic      [15:0]                o_alu_status_reg,
	output logic      [15:0]                o_cpu_control_reg,
	output logic      [3:0]                 o_cpu_priority_level,
	output logic                            o_user_irq_blocked,
	output logic                            o_prog_space_window_en,
	output logic      [PC_W-1:0]            o_program_counter,
	output logic      [PAGE_W-1:0]          o_window_page_reg
);
	// ****************************************************************
	// Flag state
	// ****************************************************************
	logic       half_carry_flag_r;
	logic [2:0] ipl_low_r;
	logic       loop_running_flag_r;
	logic       neg_r;
	logic       ov_r;
	logic       zero_r;
	logic       carry_r;
	logic       priority_level_msb_r;
	logic       prog_space_window_en_r;
	logic       ipl_blocked_nxt;

	// ****************************************************************
	// Result decoding
	// ****************************************************************
	function automatic logic half_carry(input cpu_status_pkg::alu_flags_t a);
		// Borrow sense is already folded in by the adder for subtracts
		return a.byte_op ? a.hc_out_b4 : a.hc_out_b8;
	endfunction

	// Byte operations take sign and zero from the low byte only
	function automatic logic is_neg(input cpu_status_pkg::alu_flags_t a);
		return a.byte_op ? a.result[7] : a.result[15];
	endfunction

	function automatic logic is_zero(input cpu_status_pkg::alu_flags_t a);
		return a.byte_op ? (a.result[7:0] == 8'h00)
		                 : (a.result == 16'h0000);
	endfunction

	// An ALU result only touches the flags its instruction selects
	function automatic logic alu_hits(input cpu_status_pkg::alu_flags_t a,
			input logic upd);
		return a.valid && upd;
	endfunction

	// ****************************************************************
	// Priority level decoding
	// ****************************************************************
	// Exception entry and return load the whole level and beat software
	function automatic logic [2:0] ipl_low_next(input logic [2:0] cur,
			input logic exc_we, input logic [3:0] exc,
			input cpu_status_pkg::reg_wr_t wr, input logic nest_dis);
		if (exc_we)
			return exc[2:0];
		if (wr.stat_we && !nest_dis)
			return wr.wdata[cpu_status_pkg::STAT_IPL_HI:
			                cpu_status_pkg::STAT_IPL_LO];
		return cur;
	endfunction

	// Software may write a zero to the msb but never a one
	function automatic logic msb_next(input logic cur, input logic exc_we,
			input logic [3:0] exc, input cpu_status_pkg::reg_wr_t wr);
		if (exc_we)
			return exc[3];
		if (wr.ctl_we && !wr.wdata[cpu_status_pkg::CTL_IPLMSB_BIT])
			return 1'b0;
		return cur;
	endfunction

	// Level seven with a clear msb, or any level above seven, masks users
	function automatic logic users_masked(input logic msb,
			input logic [2:0] low);
		return msb || (low == cpu_status_pkg::IPL_LOW_MAX);
	endfunction

	// ****************************************************************
	// ALU flags; a software write loses to an ALU update in one cycle
	// ****************************************************************
	// One result lands every cycle, single-cycle multiplies included,
	// so flag updates never hold back the instruction stream
	always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
		if (i_sys_rst)
			half_carry_flag_r <= 1'b0;
		else if (alu_hits(i_alu, i_alu.upd_hc))
			half_carry_flag_r <= half_carry(i_alu);
		else if (i_wr.stat_we)
			half_carry_flag_r <= i_wr.wdata[cpu_status_pkg::STAT_HC_BIT];
	end

	always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
		if (i_sys_rst)
			neg_r <= 1'b0;
		else if (alu_hits(i_alu, i_alu.upd_neg))
			neg_r <= is_neg(i_alu);
		else if (i_wr.stat_we)
			neg_r <= i_wr.wdata[cpu_status_pkg::STAT_NEG_BIT];
	end

	always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
		if (i_sys_rst)
			ov_r <= 1'b0;
		else if (alu_hits(i_alu, i_alu.upd_ov))
			ov_r <= i_alu.overflow;
		else if (i_wr.stat_we)
			ov_r <= i_wr.wdata[cpu_status_pkg::STAT_OV_BIT];
	end

	// Zero follows the result: non-zero clears, zero sets, others leave it
	always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
		if (i_sys_rst)
			zero_r <= 1'b0;
		else if (alu_hits(i_alu, i_alu.upd_zero))
			zero_r <= is_zero(i_alu);
		else if (i_wr.stat_we)
			zero_r <= i_wr.wdata[cpu_status_pkg::STAT_ZERO_BIT];
	end

	// Carry comes already in borrow sense for subtracts
	always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
		if (i_sys_rst)
			carry_r <= 1'b0;
		else if (alu_hits(i_alu, i_alu.upd_carry))
			carry_r <= i_alu.carry_out;
		else if (i_wr.stat_we)
			carry_r <= i_wr.wdata[cpu_status_pkg::STAT_CARRY_BIT];
	end

	// ****************************************************************
	// Repeat loop indicator, read-only to software
	// ****************************************************************
	// Only the loop sequencer drives this bit; status writes skip it
	always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
		if (i_sys_rst)
			loop_running_flag_r <= 1'b0;
		else
			loop_running_flag_r <= i_loop_running;
	end

	// ****************************************************************
	// Priority level
	// ****************************************************************
	always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
		if (i_sys_rst)
			ipl_low_r <= 3'h0;
		else
			ipl_low_r <= ipl_low_next(ipl_low_r, i_exc_ipl_we, i_exc_ipl,
				i_wr, i_nesting_disable);
	end

	// Software can only clear the msb; the exception logic sets it
	always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
		if (i_sys_rst)
			priority_level_msb_r <= 1'b0;
		else
			priority_level_msb_r <= msb_next(priority_level_msb_r,
				i_exc_ipl_we, i_exc_ipl, i_wr);
	end

	// Window enable is fully writable, unlike the msb beside it
	always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
		if (i_sys_rst)
			prog_space_window_en_r <= 1'b0;
		else if (i_wr.ctl_we)
			prog_space_window_en_r <=
				i_wr.wdata[cpu_status_pkg::CTL_PSV_BIT];
	end

	// ****************************************************************
	// Read-back images, registered so outputs come from flops
	// ****************************************************************
	logic [15:0] stat_nxt;
	logic [15:0] ctl_nxt;
	logic [2:0]  ipl_nxt;
	logic        msb_nxt;

	// Level next values track the state updates above one cycle early
	always_comb begin
		ipl_nxt = ipl_low_next(ipl_low_r, i_exc_ipl_we, i_exc_ipl, i_wr,
			i_nesting_disable);
		msb_nxt = msb_next(priority_level_msb_r, i_exc_ipl_we, i_exc_ipl,
			i_wr);
		ipl_blocked_nxt = users_masked(msb_nxt, ipl_nxt);
	end

	// Unimplemented status bits are masked so they always read zero
	always_comb begin
		stat_nxt = 16'h0000;
		stat_nxt[cpu_status_pkg::STAT_HC_BIT]    = half_carry_flag_r;
		stat_nxt[cpu_status_pkg::STAT_IPL_HI:
		         cpu_status_pkg::STAT_IPL_LO]    = ipl_low_r;
		stat_nxt[cpu_status_pkg::STAT_LOOP_BIT]  = loop_running_flag_r;
		stat_nxt[cpu_status_pkg::STAT_NEG_BIT]   = neg_r;
		stat_nxt[cpu_status_pkg::STAT_OV_BIT]    = ov_r;
		stat_nxt[cpu_status_pkg::STAT_ZERO_BIT]  = zero_r;
		stat_nxt[cpu_status_pkg::STAT_CARRY_BIT] = carry_r;
		stat_nxt = stat_nxt & cpu_status_pkg::STAT_MASK;
	end

	// Control keeps only the level msb and the window enable
	always_comb begin
		ctl_nxt = 16'h0000;
		ctl_nxt[cpu_status_pkg::CTL_IPLMSB_BIT] = priority_level_msb_r;
		ctl_nxt[cpu_status_pkg::CTL_PSV_BIT]    = prog_space_window_en_r;
		ctl_nxt = ctl_nxt & cpu_status_pkg::CTL_MASK;
	end

	// Images lag the flag flops by one cycle: a registered read port
	always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
		if (i_sys_rst)
			o_alu_status_reg <= cpu_status_pkg::STAT_RESET;
		else
			o_alu_status_reg <= stat_nxt;
	end

	always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
		if (i_sys_rst)
			o_cpu_control_reg <= cpu_status_pkg::CTL_RESET;
		else
			o_cpu_control_reg <= ctl_nxt;
	end

	// Enable is copied, not decoded, so it matches the control image
	always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
		if (i_sys_rst)
			o_prog_space_window_en <= 1'b0;
		else
			o_prog_space_window_en <= prog_space_window_en_r;
	end

	// Level outputs use next values so they lead the status image
	always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
		if (i_sys_rst)
			o_cpu_priority_level <= 4'h0;
		else
			o_cpu_priority_level <= {msb_nxt, ipl_nxt};
	end

	always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
		if (i_sys_rst)
			o_user_irq_blocked <= 1'b0;
		else
			o_user_irq_blocked <= ipl_blocked_nxt;
	end

	// ****************************************************************
	// Program counter and visibility page
	// ****************************************************************
	// The whole program space is reachable; any 23-bit value loads
	always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
		if (i_sys_rst)
			o_program_counter <= '0;
		else if (i_pc_we)
			o_program_counter <= i_pc_nxt;
	end

	// Page picks which program window appears in upper data space
	always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
		if (i_sys_rst)
			o_window_page_reg <= '0;
		else if (i_page_we)
			o_window_page_reg <= i_page;
	end
endmodule
`default_nettype wire

/* File: rtl/cpu_status_pkg.sv */
`default_nettype none
package cpu_status_pkg;
	// ****************************************************************
	// Register layout
	// ****************************************************************
	localparam int REG_W          = 16;
	localparam int STAT_HC_BIT    = 8;
	localparam int STAT_IPL_HI    = 7;
	localparam int STAT_IPL_LO    = 5;
	localparam int STAT_LOOP_BIT  = 4;
	localparam int STAT_NEG_BIT   = 3;
	localparam int STAT_OV_BIT    = 2;
	localparam int STAT_ZERO_BIT  = 1;
	localparam int STAT_CARRY_BIT = 0;
	localparam int CTL_IPLMSB_BIT = 3;
	localparam int CTL_PSV_BIT    = 2;
	localparam logic [15:0] STAT_RESET = 16'h0000;
	localparam logic [15:0] CTL_RESET  = 16'h0000;
	localparam logic [15:0] STAT_MASK  = 16'h01FF;
	localparam logic [15:0] CTL_MASK   = 16'h000C;
	localparam logic [2:0]  IPL_LOW_MAX = 3'h7;
	// ****************************************************************
	// Core facts
	// ****************************************************************
	localparam int PC_W        = 23;
	localparam int PAGE_W      = 8;
	localparam int DIV_CYCLES  = 19;

	// One ALU result as it reaches the flag logic
	typedef struct packed {
		logic        valid;
		logic        byte_op;
		logic        sub_op;
		logic        carry_out;
		logic        hc_out_b4;
		logic        hc_out_b8;
		logic        overflow;
		logic [15:0] result;
		logic        upd_hc;
		logic        upd_carry;
		logic        upd_ov;
		logic        upd_zero;
		logic        upd_neg;
	} alu_flags_t;

	// Software write port
	typedef struct packed {
		logic        stat_we;
		logic        ctl_we;
		logic [15:0] wdata;
	} reg_wr_t;
endpackage
`default_nettype wire

/* File: testbench/cpu_status_monitor.sv */
`default_nettype none
module cpu_status_monitor #(
	parameter int PC_W   = cpu_status_pkg::PC_W,
	parameter int PAGE_W = cpu_status_pkg::PAGE_W
) (
	input wire logic                       i_core_clk,
	input wire logic                       i_sys_rst,
	input wire cpu_status_pkg::alu_flags_t i_alu,
	input wire cpu_status_pkg::reg_wr_t    i_wr,
	input wire logic                       i_loop_running,
	input wire logic                       i_nesting_disable,
	input wire logic                       i_exc_ipl_we,
	input wire logic [3:0]                 i_exc_ipl,
	input wire logic                       i_pc_we,
	input wire logic [PC_W-1:0]            i_pc_nxt,
	input wire logic                       i_page_we,
	input wire logic [PAGE_W-1:0]          i_page,
	input wire logic [15:0]                o_alu_status_reg,
	input wire logic [15:0]                o_cpu_control_reg,
	input wire logic [3:0]                 o_cpu_priority_level,
	input wire logic                       o_user_irq_blocked,
	input wire logic                       o_prog_space_window_en,
	input wire logic [PC_W-1:0]            o_program_counter,
	input wire logic [PAGE_W-1:0]          o_window_page_reg
);
	default clocking @(posedge i_core_clk); endclocking
	default disable iff (i_sys_rst);
	// Byte results take sign and zero from the low byte, so only words here
	sequence alu_word_s;
		i_alu.valid && !i_alu.byte_op;
	endsequence
	upper_zero_a: assert property (o_alu_status_reg[15:9] == 7'h00)
		else $error("status upper bits set");
	carry_flag_a: assert property (i_alu.valid && i_alu.upd_carry |->
		##2 o_alu_status_reg[0] == $past(i_alu.carry_out, 2))
		else $error("carry flag wrong");
	neg_word_a: assert property (alu_word_s ##0 i_alu.upd_neg |->
		##2 o_alu_status_reg[3] == $past(i_alu.result[15], 2))
		else $error("negative flag wrong");
	zero_word_a: assert property (alu_word_s ##0 i_alu.upd_zero |->
		##2 o_alu_status_reg[1] == ($past(i_alu.result, 2) == 16'h0000))
		else $error("zero flag wrong");
	loop_flag_a: assert property (!$past(i_sys_rst, 2) |->
		o_alu_status_reg[4] == $past(i_loop_running, 2))
		else $error("loop flag does not follow input");
	level_image_a: assert property (
		o_alu_status_reg[7:5] == $past(o_cpu_priority_level[2:0]) &&
		o_cpu_control_reg[3] == $past(o_cpu_priority_level[3]))
		else $error("priority image mismatch");
	blocked_a: assert property (o_user_irq_blocked ==
		(o_cpu_priority_level[3] || &o_cpu_priority_level[2:0]))
		else $error("user block wrong");
	nest_lock_a: assert property (i_nesting_disable && !i_exc_ipl_we |=>
		$stable(o_cpu_priority_level[2:0]))
		else $error("locked priority changed");
	msb_clear_a: assert property (!i_exc_ipl_we |=>
		!$rose(o_cpu_priority_level[3]))
		else $error("priority msb set by software");
	pc_load_a: assert property (i_pc_we |=>
		o_program_counter == $past(i_pc_nxt))
		else $error("program counter not loaded");
	window_en_a: assert property (i_wr.ctl_we |-> ##2
		o_prog_space_window_en == $past(i_wr.wdata[2], 2) &&
		o_cpu_control_reg[2] == $past(i_wr.wdata[2], 2))
		else $error("window enable does not follow write");
endmodule

bind cpu_status_control_regs cpu_status_monitor #(
	.PC_W(PC_W), .PAGE_W(PAGE_W)
) u_monitor (
	.i_core_clk(i_core_clk), .i_sys_rst(i_sys_rst), .i_alu(i_alu),
	.i_wr(i_wr), .i_loop_running(i_loop_running),
	.i_nesting_disable(i_nesting_disable), .i_exc_ipl_we(i_exc_ipl_we),
	.i_exc_ipl(i_exc_ipl), .i_pc_we(i_pc_we), .i_pc_nxt(i_pc_nxt),
	.i_page_we(i_page_we), .i_page(i_page),
	.o_alu_status_reg(o_alu_status_reg),
	.o_cpu_control_reg(o_cpu_control_reg),
	.o_cpu_priority_level(o_cpu_priority_level),
	.o_user_irq_blocked(o_user_irq_blocked),
	.o_prog_space_window_en(o_prog_space_window_en),
	.o_program_counter(o_program_counter),
	.o_window_page_reg(o_window_page_reg)
);
`default_nettype wire

/* File: testbench/tb.sv */
`default_nettype none
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic                            clk, rst, loop_run, nest;
	logic                            exc_we, pc_we, pg_we, blk, prog_space_window_en;
	logic [3:0]                      exc, lvl;
	logic [15:0]                     st, ct;
	logic [cpu_status_pkg::PC_W-1:0] pc, pc_o;
	logic [7:0]                      pg, pg_o;
	cpu_status_pkg::alu_flags_t      alu;
	cpu_status_pkg::reg_wr_t         wr;
	int                              failures, n_compared;
	cpu_status_control_regs dut (
		.i_core_clk(clk), .i_sys_rst(rst), .i_alu(alu), .i_wr(wr),
		.i_loop_running(loop_run), .i_nesting_disable(nest),
		.i_exc_ipl_we(exc_we), .i_exc_ipl(exc), .i_pc_we(pc_we),
		.i_pc_nxt(pc), .i_page_we(pg_we), .i_page(pg),
		.o_alu_status_reg(st), .o_cpu_control_reg(ct),
		.o_cpu_priority_level(lvl), .o_user_irq_blocked(blk),
		.o_prog_space_window_en(prog_space_window_en), .o_program_counter(pc_o),
		.o_window_page_reg(pg_o)
	);
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	task automatic chk(input string nm, input logic [31:0] e, g);
		n_compared++;
		if (g !== e) begin
			failures++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask
	// Sample 1 ns after an edge so that edge's updates have landed
	task automatic step(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic wr_reg(input logic s, input logic [15:0] d);
		@(posedge clk);
		wr <= '{stat_we: s, ctl_we: !s, wdata: d};
		@(posedge clk);
		wr <= '0;
	endtask
	task automatic alu_op(input logic b, input logic [15:0] r,
			input logic [3:0] f, input logic [4:0] u);
		cpu_status_pkg::alu_flags_t a;
		a = '0;
		a.valid = 1'b1;
		a.byte_op = b;
		a.result = r;
		{a.carry_out, a.hc_out_b4, a.hc_out_b8, a.overflow} = f;
		{a.upd_hc, a.upd_carry, a.upd_ov, a.upd_zero, a.upd_neg} = u;
		@(posedge clk);
		alu <= a;
		@(posedge clk);
		alu <= '0;
	endtask
	task automatic end_of_test();
		$display("compared %0d failures %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	initial begin
		repeat (2000) @(posedge clk);
		failures++;
		end_of_test();
	end
	initial begin
		rst = 1'b1;
		{loop_run, nest, exc_we, pc_we, pg_we} = 5'h00;
		{exc, pc, pg} = '0;
		alu = '0;
		wr = '0;
		failures = 0;
		n_compared = 0;
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		step(1);
		chk("status", 32'h0, 32'(st));
		chk("control", 32'h0, 32'(ct));
		wr_reg(1'b1, 16'hFFFF);
		step(0);
		chk("level", 32'h7, 32'(lvl));
		chk("blocked", 32'h1, 32'(blk));
		step(1);
		chk("status", 32'h01EF, 32'(st));
		@(posedge clk);
		nest <= 1'b1;
		wr_reg(1'b1, 16'h0000);
		step(1);
		chk("status", 32'h00E0, 32'(st));
		@(posedge clk);
		nest <= 1'b0;
		exc_we <= 1'b1;
		exc <= 4'hA;
		@(posedge clk);
		exc_we <= 1'b0;
		step(0);
		chk("level", 32'hA, 32'(lvl));
		chk("blocked", 32'h1, 32'(blk));
		step(1);
		chk("control", 32'h0008, 32'(ct));
		chk("status", 32'h0040, 32'(st));
		wr_reg(1'b0, 16'h0000);
		step(0);
		chk("blocked", 32'h0, 32'(blk));
		wr_reg(1'b0, 16'hFFFF);
		step(1);
		chk("control", 32'h0004, 32'(ct));
		chk("window", 32'h1, 32'(prog_space_window_en));
		alu_op(1'b0, 16'h8000, 4'b1011, 5'h1F);
		step(1);
		chk("status", 32'h014D, 32'(st));
		alu_op(1'b1, 16'h0000, 4'b0010, 5'h1F);
		step(1);
		chk("status", 32'h0042, 32'(st));
		@(posedge clk);
		loop_run <= 1'b1;
		alu_op(1'b0, 16'h0001, 4'b1000, 5'h08);
		step(1);
		chk("status", 32'h0053, 32'(st));
		alu_op(1'b1, 16'h0080, 4'b0100, 5'h11);
		step(1);
		chk("status", 32'h015B, 32'(st));
		@(posedge clk);
		{pc_we, pg_we, loop_run} <= 3'b110;
		pc <= 23'h7FFFFF;
		pg <= 8'hA5;
		@(posedge clk);
		{pc_we, pg_we} <= 2'b00;
		step(0);
		chk("pc", 32'h7FFFFF, 32'(pc_o));
		chk("page", 32'hA5, 32'(pg_o));
		@(posedge clk);
		rst <= 1'b1;
		step(2);
		chk("status", 32'h0, 32'(st));
		chk("level", 32'h0, 32'(lvl));
		end_of_test();
	end
endmodule
`default_nettype wire
